// file: logic/crs_pkg.sv
// Package: constants and carrier types of the CPU register set and addressing block
package crs_pkg;
  localparam int  CRS_DW         = 8;
  localparam int  CRS_AW         = 16;
  localparam int  CRS_PCW        = 14;
  localparam int  CRS_SPW        = 6;
  localparam logic [9:0]  CRS_SP_FIXED   = 10'h003;
  localparam logic [5:0]  CRS_SP_TOP     = 6'h3f;
  localparam logic [2:0]  CRS_CCR_ONES   = 3'h7;
  localparam logic [7:0]  CRS_ZERO_BYTE  = 8'h00;
  localparam logic [13:0] CRS_PC_RESET   = 14'h0000;
  localparam logic [3:0]  CRS_MUL_CYCLES = 4'hb;
  localparam logic [3:0]  CRS_MUL_STEPS  = 4'h8;
  localparam int  CRS_CCR_C      = 0;
  localparam int  CRS_CCR_Z      = 1;
  localparam int  CRS_CCR_N      = 2;
  localparam int  CRS_CCR_I      = 3;
  localparam int  CRS_CCR_H      = 4;

  typedef enum logic [2:0] {
    CRS_AM_INH  = 3'b000,
    CRS_AM_IMM  = 3'b001,
    CRS_AM_DIR  = 3'b010,
    CRS_AM_EXT  = 3'b011,
    CRS_AM_IX   = 3'b100,
    CRS_AM_IX1  = 3'b101,
    CRS_AM_IX2  = 3'b110,
    CRS_AM_REL  = 3'b111
  } crs_amode_t;

  typedef enum logic [3:0] {
    CRS_OP_NOP  = 4'h0,
    CRS_OP_ADD  = 4'h1,
    CRS_OP_ADC  = 4'h2,
    CRS_OP_SUB  = 4'h3,
    CRS_OP_SBC  = 4'h4,
    CRS_OP_AND  = 4'h5,
    CRS_OP_OR   = 4'h6,
    CRS_OP_XOR  = 4'h7,
    CRS_OP_LDA  = 4'h8,
    CRS_OP_LDX  = 4'h9,
    CRS_OP_INC_ACC = 4'ha,
    CRS_OP_SETC = 4'hb,
    CRS_OP_CLC  = 4'hc,
    CRS_OP_CMP  = 4'hd
  } crs_aluop_t;

  typedef enum logic [1:0] {
    CRS_ST_RUN  = 2'b00,
    CRS_ST_MUL  = 2'b01
  } crs_state_t;

  // Addressing request from the sequencer
  typedef struct packed {
    crs_amode_t mode;
    logic [7:0] op_hi;
    logic [7:0] op_lo;
  } crs_ea_req_t;

  // Programmer-visible register image
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  ccr;
  } crs_regs_t;
endpackage

// file: logic/crs_ea_gen.sv
// Effective-address former for the eight addressing modes
`timescale 1ns/1ps
module crs_ea_gen (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  input  wire crs_pkg::crs_ea_req_t i_req,
  input  wire logic [7:0]           i_idx,
  input  wire logic [13:0]          i_pc,
  output logic      [15:0]          o_ea
);
  import crs_pkg::*;

  wire logic [15:0] w_dir  = {CRS_ZERO_BYTE, i_req.op_lo};
  wire logic [15:0] w_ext  = {i_req.op_hi, i_req.op_lo};
  wire logic [15:0] w_ix   = {CRS_ZERO_BYTE, i_idx};
  wire logic [15:0] w_ix1  = {7'h00, {1'b0, i_idx} + {1'b0, i_req.op_lo}};
  wire logic [15:0] w_ix2  = {i_req.op_hi, i_req.op_lo} + {8'h00, i_idx};
  wire logic [15:0] w_rel  = {2'b00, i_pc} + {{8{i_req.op_lo[7]}}, i_req.op_lo};
  wire logic [15:0] w_sel  = (i_req.mode == CRS_AM_DIR) ? w_dir :
                             (i_req.mode == CRS_AM_EXT) ? w_ext :
                             (i_req.mode == CRS_AM_IX)  ? w_ix  :
                             (i_req.mode == CRS_AM_IX1) ? w_ix1 :
                             (i_req.mode == CRS_AM_IX2) ? w_ix2 :
                             (i_req.mode == CRS_AM_REL) ? w_rel : 16'h0000;

  // ------------------------------------------------------------
  // Registered address, top two bits dropped
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ea <= 16'h0000;
    end else if (i_ce) begin
      o_ea <= {2'b00, w_sel[CRS_PCW-1:0]};
    end
  end
endmodule

// file: logic/crs_core.sv
// Top: CPU register set, flags, multiply sequencer and address formation
`timescale 1ns/1ps
module crs_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  input  wire crs_pkg::crs_aluop_t  i_alu_op,
  input  wire logic [7:0]           i_operand,
  input  wire crs_pkg::crs_ea_req_t i_ea_req,
  input  wire logic                 i_fetch,
  input  wire logic                 i_pc_load,
  input  wire logic [15:0]          i_pc_target,
  input  wire logic                 i_branch,
  input  wire logic                 i_branch_true,
  input  wire logic                 i_push,
  input  wire logic                 i_pull,
  input  wire logic                 i_stack_pointer_reload_instr,
  input  wire logic                 i_unsigned_multiply_instr,
  input  wire logic                 i_irq,
  input  wire logic                 i_irq_taken,
  input  wire logic                 i_return_from_interrupt_instr,
  input  wire logic [7:0]           i_ccr_restore,
  input  wire logic                 i_mask_set_instr,
  input  wire logic                 i_mask_clear_instr,
  output crs_pkg::crs_regs_t        o_regs,
  output logic      [15:0]          o_ea,
  output logic      [2:0]           o_instr_len,
  output logic                      o_irq_pending,
  output logic                      o_irq_service,
  output logic                      o_mul_busy,
  output logic      [2:0]           o_entry_push_bytes
);
  import crs_pkg::*;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0]          acc_ff;
  logic [7:0]          nxt_acc;
  logic [7:0]          idx_ff;
  logic [7:0]          nxt_idx;
  logic [5:0]          sp_ff;
  logic [5:0]          nxt_sp;
  logic [13:0]         pc_ff;
  logic [13:0]         nxt_pc;
  logic                h_ff;
  logic                i_mask_ff;
  logic                n_ff;
  logic                z_ff;
  logic                c_ff;
  logic                nxt_h;
  logic                nxt_i;
  logic                nxt_n;
  logic                nxt_z;
  logic                nxt_c;
  logic                irq_meta_ff;
  logic                irq_sync_ff;
  logic                irq_latch_ff;
  crs_state_t          state_ff;
  crs_state_t          nxt_state;
  logic [3:0]          mul_cnt_ff;
  logic [15:0]         mul_prod_ff;
  logic [7:0]          mul_mcand_ff;
  logic [15:0]         nxt_prod;
  logic [3:0]          nxt_mul_cnt;

  // ------------------------------------------------------------
  // Arithmetic decode
  // ------------------------------------------------------------
  wire logic        w_is_add  = (i_alu_op == CRS_OP_ADD) || (i_alu_op == CRS_OP_ADC);
  wire logic        w_is_sub  = (i_alu_op == CRS_OP_SUB) || (i_alu_op == CRS_OP_SBC) ||
                                (i_alu_op == CRS_OP_CMP);
  wire logic        w_cin     = ((i_alu_op == CRS_OP_ADC) || (i_alu_op == CRS_OP_SBC)) & c_ff;
  // Subtraction as negative addition, borrow is inverted carry
  wire logic [7:0]  w_b       = w_is_sub ? ~i_operand : i_operand;
  wire logic        w_cin_eff = w_is_sub ? ~w_cin : w_cin;
  wire logic [4:0]  w_lo_sum  = {1'b0, acc_ff[3:0]} + {1'b0, w_b[3:0]} + {4'h0, w_cin_eff};
  wire logic [8:0]  w_sum     = {1'b0, acc_ff} + {1'b0, w_b} + {8'h00, w_cin_eff};
  wire logic [7:0]  w_inc     = acc_ff + 8'h01;
  wire logic [7:0]  w_result  = (w_is_add || w_is_sub)         ? w_sum[7:0] :
                                (i_alu_op == CRS_OP_AND)       ? (acc_ff & i_operand) :
                                (i_alu_op == CRS_OP_OR)        ? (acc_ff | i_operand) :
                                (i_alu_op == CRS_OP_XOR)       ? (acc_ff ^ i_operand) :
                                (i_alu_op == CRS_OP_INC_ACC)   ? w_inc : i_operand;
  wire logic        w_flags   = (i_alu_op != CRS_OP_NOP) && (i_alu_op != CRS_OP_SETC) &&
                                (i_alu_op != CRS_OP_CLC);
  wire logic        w_wr_acc  = w_flags && (i_alu_op != CRS_OP_LDX) && (i_alu_op != CRS_OP_CMP);
  wire logic        w_run     = (state_ff == CRS_ST_RUN);
  wire logic        w_mul_go  = w_run && i_unsigned_multiply_instr;
  wire logic        w_mul_end = (state_ff == CRS_ST_MUL) && (mul_cnt_ff == CRS_MUL_CYCLES);
  wire logic        w_irq_svc = irq_latch_ff && !i_mask_ff && w_run;
  wire logic [2:0]  w_len     = (i_ea_req.mode == CRS_AM_INH) ? 3'h1 :
                                (i_ea_req.mode == CRS_AM_IX)  ? 3'h1 :
                                (i_ea_req.mode == CRS_AM_EXT) ? 3'h3 :
                                (i_ea_req.mode == CRS_AM_IX2) ? 3'h3 : 3'h2;

  // ------------------------------------------------------------
  // Multiply datapath
  // ------------------------------------------------------------
  // Eight add-shift steps, then idle counts pad the span to eleven
  wire logic [8:0]  w_mul_top   = {1'b0, mul_prod_ff[15:8]};
  wire logic [8:0]  w_mul_hi    = mul_prod_ff[0] ? (w_mul_top + {1'b0, mul_mcand_ff}) : w_mul_top;
  wire logic [15:0] w_mul_shift = {w_mul_hi, mul_prod_ff[7:1]};
  wire logic        w_mul_step  = (state_ff == CRS_ST_MUL) && (mul_cnt_ff <= CRS_MUL_STEPS);
  assign nxt_mul_cnt = w_mul_go  ? 4'h1 :
                       w_mul_end ? 4'h0 :
                       (state_ff == CRS_ST_MUL) ? (mul_cnt_ff + 4'h1) : mul_cnt_ff;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    nxt_acc   = acc_ff;
    nxt_idx   = idx_ff;
    nxt_h     = h_ff;
    nxt_n     = n_ff;
    nxt_z     = z_ff;
    nxt_c     = c_ff;
    nxt_state = state_ff;
    nxt_prod  = mul_prod_ff;
    case (state_ff)
      CRS_ST_RUN: begin
        if (w_mul_go) begin
          nxt_state = CRS_ST_MUL;
          nxt_prod  = {CRS_ZERO_BYTE, idx_ff};
        end else begin
          if (w_wr_acc) begin
            nxt_acc = w_result;
          end
          if (i_alu_op == CRS_OP_LDX) begin
            nxt_idx = i_operand;
          end
          if (w_flags) begin
            nxt_n = w_result[7];
            nxt_z = (w_result == CRS_ZERO_BYTE);
          end
          if (w_is_add) begin
            nxt_h = w_lo_sum[4];
            nxt_c = w_sum[8];
          end else if (w_is_sub) begin
            nxt_c = ~w_sum[8];
          end else if (i_alu_op == CRS_OP_SETC) begin
            nxt_c = 1'b1;
          end else if (i_alu_op == CRS_OP_CLC) begin
            nxt_c = 1'b0;
          end
        end
      end
      CRS_ST_MUL: begin
        // One add-shift step per cycle up to count eight; the final count, eleven, lands the result
        if (w_mul_step) begin
          nxt_prod = w_mul_shift;
        end
        if (w_mul_end) begin
          nxt_idx   = mul_prod_ff[15:8];
          nxt_acc   = mul_prod_ff[7:0];
          nxt_h     = 1'b0;
          nxt_c     = 1'b0;
          nxt_state = CRS_ST_RUN;
        end
      end
      default: begin
        nxt_state = CRS_ST_RUN;
      end
    endcase
  end

  // Mask: set on entry and reset, cleared only by instructions
  assign nxt_i = w_irq_svc                     ? 1'b1 :
                 i_return_from_interrupt_instr ? i_ccr_restore[CRS_CCR_I] :
                 i_mask_set_instr              ? 1'b1 :
                 i_mask_clear_instr            ? 1'b0 : i_mask_ff;

  // Stack: five bytes per entry, two per call, driven byte by byte
  assign nxt_sp = i_stack_pointer_reload_instr ? CRS_SP_TOP :
                  i_push                       ? sp_ff - 6'h01 :
                  i_pull                       ? sp_ff + 6'h01 : sp_ff;

  assign nxt_pc = i_irq_taken                  ? i_pc_target[CRS_PCW-1:0] :
                  i_pc_load                    ? i_pc_target[CRS_PCW-1:0] :
                  (i_branch && i_branch_true)  ? o_ea[CRS_PCW-1:0] :
                  i_fetch                      ? pc_ff + 14'h0001 : pc_ff;

  // ------------------------------------------------------------
  // Flag restore
  // ------------------------------------------------------------
  // Return reloads the stacked H, N, Z and C flags; ALU flag updates that cycle are dropped, the accumulator write is not
  wire logic        w_ret       = i_return_from_interrupt_instr;
  wire logic        w_ret_h     = w_ret ? i_ccr_restore[CRS_CCR_H] : nxt_h;
  wire logic        w_ret_n     = w_ret ? i_ccr_restore[CRS_CCR_N] : nxt_n;
  wire logic        w_ret_z     = w_ret ? i_ccr_restore[CRS_CCR_Z] : nxt_z;
  wire logic        w_ret_c     = w_ret ? i_ccr_restore[CRS_CCR_C] : nxt_c;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Index and accumulator are unaffected by reset
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      acc_ff <= nxt_acc;
      idx_ff <= nxt_idx;
      mul_prod_ff <= nxt_prod;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sp_ff     <= CRS_SP_TOP;
      pc_ff     <= CRS_PC_RESET;
      i_mask_ff <= 1'b1;
      state_ff  <= CRS_ST_RUN;
    end else if (i_ce) begin
      sp_ff     <= nxt_sp;
      pc_ff     <= nxt_pc;
      i_mask_ff <= nxt_i;
      state_ff  <= nxt_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      h_ff <= 1'b0;
      n_ff <= 1'b0;
      z_ff <= 1'b0;
      c_ff <= 1'b0;
    end else if (i_ce) begin
      h_ff <= w_ret_h;
      n_ff <= w_ret_n;
      z_ff <= w_ret_z;
      c_ff <= w_ret_c;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mul_cnt_ff   <= 4'h0;
      mul_mcand_ff <= 8'h00;
    end else if (i_ce) begin
      mul_cnt_ff   <= nxt_mul_cnt;
      mul_mcand_ff <= w_mul_go ? acc_ff : mul_mcand_ff;
    end
  end

  // Request pin synchronised before the latch; set beats the service clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_meta_ff  <= 1'b0;
      irq_sync_ff  <= 1'b0;
      irq_latch_ff <= 1'b0;
    end else if (i_ce) begin
      irq_meta_ff  <= i_irq;
      irq_sync_ff  <= irq_meta_ff;
      irq_latch_ff <= irq_sync_ff | (irq_latch_ff & ~w_irq_svc);
    end
  end

  // ------------------------------------------------------------
  // Address former and outputs
  // ------------------------------------------------------------
  crs_ea_gen u_ea (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_req  (i_ea_req),
    .i_idx  (idx_ff),
    .i_pc   (pc_ff),
    .o_ea   (o_ea)
  );

  assign o_regs.acc          = acc_ff;
  assign o_regs.idx          = idx_ff;
  assign o_regs.sp           = {CRS_SP_FIXED, sp_ff};
  assign o_regs.pc           = {2'b00, pc_ff};
  assign o_regs.ccr          = {CRS_CCR_ONES, h_ff, i_mask_ff, n_ff, z_ff, c_ff};
  assign o_instr_len         = w_len;
  assign o_irq_pending       = irq_latch_ff;
  assign o_irq_service       = w_irq_svc;
  assign o_mul_busy          = !w_run;
  assign o_entry_push_bytes  = w_irq_svc ? 3'h5 : 3'h2;
endmodule

// file: tb/crs_mem_model.sv
// Behavioural memory bus partner answering operand reads
`timescale 1ns/1ps
module crs_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_data
);
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Registered read: data lags the address by one edge, as a synchronous RAM does
  always_ff @(posedge i_clk) begin
    o_data <= i_addr[7:0] ^ i_addr[15:8] ^ 8'ha5;
  end
endmodule

// file: tb/crs_core_props.sv
// Concurrent checks on the register set core ports
`timescale 1ns/1ps
module crs_core_props
  import crs_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  input  wire crs_pkg::crs_ea_req_t i_ea_req,
  input  wire logic                 i_fetch,
  input  wire logic                 i_pc_load,
  input  wire logic                 i_branch,
  input  wire logic                 i_push,
  input  wire logic                 i_pull,
  input  wire logic                 i_stack_pointer_reload_instr,
  input  wire logic                 i_unsigned_multiply_instr,
  input  wire logic                 i_irq_taken,
  input  wire crs_pkg::crs_regs_t   o_regs,
  input  wire logic [15:0]          o_ea,
  input  wire logic                 o_irq_pending,
  input  wire logic                 o_irq_service,
  input  wire logic                 o_mul_busy,
  input  wire logic [2:0]           o_entry_push_bytes
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // Multiply tracking
  // ----------------------------------------
  logic [3:0]  mul_cnt_ff;
  logic [15:0] prod_ff;
  // Counts enabled cycles only, so a frozen core is not blamed
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !o_mul_busy) begin
      mul_cnt_ff <= 4'h0;
    end else if (i_ce) begin
      mul_cnt_ff <= mul_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_ce && i_unsigned_multiply_instr && !o_mul_busy) begin
      prod_ff <= 16'(o_regs.acc) * 16'(o_regs.idx);
    end
  end
  sequence mul_go;
    i_ce && i_unsigned_multiply_instr && !o_mul_busy;
  endsequence
  // Reset also drops busy, hence the guard on the previous reset level
  sequence mul_end;
    $fell(o_mul_busy) && $past(i_rstn);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mul_starts: assert property (mul_go |=> o_mul_busy)
    else $error("multiply did not start");
  a_mul_span: assert property (mul_end |-> mul_cnt_ff == 4'hb)
    else $error("multiply busy span wrong");
  a_mul_product: assert property (mul_end |-> {o_regs.idx, o_regs.acc} == prod_ff)
    else $error("multiply product wrong");
  a_reset_state: assert property (disable iff (1'b0)
    !i_rstn && i_ce |=> o_regs.sp == 16'h00ff && o_regs.pc == 16'h0000
    && o_regs.ccr == 8'he8 && !o_irq_pending) else $error("reset state wrong");
  a_sp_fixed: assert property (o_regs.sp[15:6] == 10'h003)
    else $error("stack pointer upper bits wrong");
  a_ccr_ones: assert property (o_regs.ccr[7:5] == 3'h7)
    else $error("condition code upper bits wrong");
  a_addr_top: assert property (o_regs.pc[15:14] == 2'h0 && o_ea[15:14] == 2'h0)
    else $error("address upper bits not zero");
  a_push_dec: assert property (i_ce && i_push && !i_pull && !i_stack_pointer_reload_instr
    |=> o_regs.sp[5:0] == $past(o_regs.sp[5:0]) - 6'h01) else $error("push did not decrement");
  a_reload_top: assert property (i_ce && i_stack_pointer_reload_instr && !i_push && !i_pull
    |=> o_regs.sp == 16'h00ff) else $error("stack reload wrong");
  a_fetch_inc: assert property (i_ce && i_fetch && !i_pc_load && !i_irq_taken && !i_branch
    |=> o_regs.pc[13:0] == $past(o_regs.pc[13:0]) + 14'h0001) else $error("fetch step wrong");
  a_service_cond: assert property (
    o_irq_service == (o_irq_pending && !o_regs.ccr[3] && !o_mul_busy))
    else $error("interrupt service condition wrong");
  a_entry_bytes: assert property (o_entry_push_bytes == (o_irq_service ? 3'h5 : 3'h2))
    else $error("stacked byte count wrong");
  a_direct_ea: assert property (i_ce && i_ea_req.mode == CRS_AM_DIR
    |=> o_ea == {8'h00, $past(i_ea_req.op_lo)}) else $error("direct address wrong");
endmodule

bind crs_core crs_core_props i_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_ea_req(i_ea_req), .i_fetch(i_fetch),
  .i_pc_load(i_pc_load), .i_branch(i_branch), .i_push(i_push), .i_pull(i_pull),
  .i_stack_pointer_reload_instr(i_stack_pointer_reload_instr), .i_irq_taken(i_irq_taken),
  .i_unsigned_multiply_instr(i_unsigned_multiply_instr), .o_regs(o_regs), .o_ea(o_ea),
  .o_irq_pending(o_irq_pending), .o_irq_service(o_irq_service), .o_mul_busy(o_mul_busy),
  .o_entry_push_bytes(o_entry_push_bytes)
);

// file: tb/tb.sv
// Self-checking bench for the register set and addressing core
`timescale 1ns/1ps
module tb;
  import crs_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [11:0] FETCH = 12'h001, LOAD = 12'h002, BR = 12'h00c, PUSH = 12'h010;
  localparam logic [11:0] PULL = 12'h020, RELOAD = 12'h040, MULT = 12'h080, TAKEN = 12'h100;
  localparam logic [11:0] RESTORE = 12'h200, MSET = 12'h400, MCLR = 12'h800;
  logic        i_clk;
  logic        i_rstn;
  logic        ce;
  logic        irq;
  logic        use_mem;
  logic [11:0] ctl;
  logic [7:0]  opnd;
  logic [7:0]  ccr_rst;
  logic [7:0]  mem_q;
  logic [15:0] tgt;
  logic [15:0] ea;
  logic [2:0]  len;
  logic [2:0]  ebytes;
  logic        pend;
  logic        serv;
  logic        busy;
  crs_aluop_t  aop;
  crs_ea_req_t req;
  crs_regs_t   regs;
  int          fails;
  int          compares;

  crs_core i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_alu_op(aop),
    .i_operand(use_mem ? mem_q : opnd), .i_ea_req(req), .i_fetch(ctl[0]),
    .i_pc_load(ctl[1]), .i_pc_target(tgt), .i_branch(ctl[2]), .i_branch_true(ctl[3]),
    .i_push(ctl[4]), .i_pull(ctl[5]), .i_stack_pointer_reload_instr(ctl[6]),
    .i_unsigned_multiply_instr(ctl[7]), .i_irq(irq), .i_irq_taken(ctl[8]),
    .i_return_from_interrupt_instr(ctl[9]), .i_ccr_restore(ccr_rst),
    .i_mask_set_instr(ctl[10]), .i_mask_clear_instr(ctl[11]), .o_regs(regs), .o_ea(ea),
    .o_instr_len(len), .o_irq_pending(pend), .o_irq_service(serv), .o_mul_busy(busy),
    .o_entry_push_bytes(ebytes)
  );
  crs_mem_model i_mem (.i_clk(i_clk), .i_addr(ea), .o_data(mem_q));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe held over n edges, so back-to-back bytes are one call
  task automatic pulse(input logic [11:0] m, input int n);
    @(posedge i_clk);
    ctl <= m;
    repeat (n) @(posedge i_clk);
    ctl <= '0;
    #1;
  endtask
  task automatic jump(input logic [11:0] m, input logic [15:0] t);
    @(posedge i_clk);
    tgt <= t;
    ctl <= m;
    @(posedge i_clk);
    ctl <= '0;
    #1;
  endtask
  task automatic alu(input crs_aluop_t op, input logic [7:0] v);
    @(posedge i_clk);
    aop <= op;
    opnd <= v;
    @(posedge i_clk);
    aop <= CRS_OP_NOP;
    #1;
  endtask
  task automatic ea_chk(input crs_amode_t m, input logic [15:0] op, input logic [15:0] e,
                        input logic [2:0] l);
    @(posedge i_clk);
    req <= '{m, op[15:8], op[7:0]};
    @(posedge i_clk);
    #1;
    // Inherent and immediate forms drive address zero, which is not checked
    if (m != CRS_AM_INH && m != CRS_AM_IMM) chk("ea", e, ea);
    chk("len", 16'(l), 16'(len));
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    chk("sp_rst", 16'h00ff, regs.sp);
    chk("pc_rst", 16'h0000, regs.pc);
    chk("ccr_rst", 8'he8, regs.ccr);
    chk("busy_rst", 1'h0, busy);
    $display("test reset done");
  endtask
  task automatic t_stack();
    pulse(PUSH, 1);
    chk("sp_push", 16'h00fe, regs.sp);
    pulse(PULL, 1);
    chk("sp_pull", 16'h00ff, regs.sp);
    pulse(PUSH, 64);
    chk("sp_wrap", 16'h00ff, regs.sp);
    pulse(PULL, 1);
    chk("sp_wrap_up", 16'h00c0, regs.sp);
    pulse(PUSH, 5);
    pulse(RELOAD, 1);
    chk("sp_reload", 16'h00ff, regs.sp);
    chk("call_bytes", 3'h2, ebytes);
    $display("test stack done");
  endtask
  task automatic t_alu();
    alu(CRS_OP_LDA, 8'h08);
    alu(CRS_OP_ADD, 8'h08);
    chk("acc_add", 8'h10, regs.acc);
    chk("ccr_half", 8'hf8, regs.ccr);
    alu(CRS_OP_LDA, 8'h80);
    alu(CRS_OP_ADD, 8'h80);
    chk("ccr_cz", 8'heb, regs.ccr);
    alu(CRS_OP_SUB, 8'h01);
    chk("acc_sub", 8'hff, regs.acc);
    chk("ccr_borrow", 8'hed, regs.ccr);
    alu(CRS_OP_CLC, 8'h00);
    chk("ccr_clc", 8'hec, regs.ccr);
    alu(CRS_OP_SETC, 8'h00);
    chk("ccr_sec", 8'hed, regs.ccr);
    alu(CRS_OP_ADC, 8'h00);
    chk("ccr_adc", 8'hfb, regs.ccr);
    alu(CRS_OP_INC_ACC, 8'h00);
    chk("acc_inc", 8'h01, regs.acc);
    alu(CRS_OP_CMP, 8'h02);
    chk("acc_cmp", 8'h01, regs.acc);
    chk("ccr_cmp", 8'hfd, regs.ccr);
    alu(CRS_OP_SBC, 8'h00);
    chk("ccr_sbc", 8'hfa, regs.ccr);
    alu(CRS_OP_OR, 8'h81);
    chk("acc_or", 8'h81, regs.acc);
    alu(CRS_OP_AND, 8'h0f);
    alu(CRS_OP_XOR, 8'h01);
    chk("acc_logic", 8'h00, regs.acc);
    chk("ccr_logic", 8'hfa, regs.ccr);
    alu(CRS_OP_LDX, 8'hff);
    chk("idx_ld", 8'hff, regs.idx);
    $display("test alu done");
  endtask
  task automatic t_mul();
    int n;
    alu(CRS_OP_LDA, 8'hff);
    @(posedge i_clk);
    ctl <= MULT;
    @(posedge i_clk);
    ctl <= '0;
    aop <= CRS_OP_ADD;
    opnd <= 8'h01;
    #1;
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge i_clk);
      aop <= CRS_OP_NOP;
      #1;
    end
    chk("mul_cycles", 16'h000b, n[15:0]);
    chk("mul_prod", 16'hfe01, {regs.idx, regs.acc});
    chk("mul_hc", 2'h0, {regs.ccr[4], regs.ccr[0]});
    pulse(MULT, 1);
    repeat (3) @(posedge i_clk);
    do_reset();
    $display("test multiply done");
  endtask
  task automatic t_pc();
    pulse(FETCH, 3);
    chk("pc_fetch", 16'h0003, regs.pc);
    @(posedge i_clk);
    ce <= 1'b0;
    pulse(FETCH, 2);
    chk("pc_frozen", 16'h0003, regs.pc);
    @(posedge i_clk);
    ce <= 1'b1;
    jump(LOAD, 16'hffff);
    chk("pc_trunc", 16'h3fff, regs.pc);
    pulse(FETCH, 1);
    chk("pc_roll", 16'h0000, regs.pc);
    jump(LOAD, 16'h1234);
    chk("pc_jump", 16'h1234, regs.pc);
    $display("test pc done");
  endtask
  task automatic t_ea();
    alu(CRS_OP_LDX, 8'hff);
    ea_chk(CRS_AM_INH, 16'h0000, 16'h0000, 3'h1);
    ea_chk(CRS_AM_IMM, 16'h0042, 16'h0000, 3'h2);
    ea_chk(CRS_AM_EXT, 16'hffff, 16'h3fff, 3'h3);
    ea_chk(CRS_AM_IX, 16'h0000, 16'h00ff, 3'h1);
    ea_chk(CRS_AM_IX1, 16'h00ff, 16'h01fe, 3'h2);
    ea_chk(CRS_AM_IX2, 16'h1234, 16'h1333, 3'h3);
    ea_chk(CRS_AM_REL, 16'h00fe, 16'h1232, 3'h2);
    pulse(BR, 1);
    chk("pc_branch", 16'h1232, regs.pc);
    ea_chk(CRS_AM_DIR, 16'hff42, 16'h0042, 3'h2);
    @(posedge i_clk);
    use_mem <= 1'b1;
    aop <= CRS_OP_LDA;
    @(posedge i_clk);
    use_mem <= 1'b0;
    aop <= CRS_OP_NOP;
    #1;
    chk("acc_mem", 8'he7, regs.acc);
    $display("test addressing done");
  endtask
  task automatic t_irq();
    @(posedge i_clk);
    irq <= 1'b1;
    repeat (5) @(posedge i_clk);
    irq <= 1'b0;
    #1;
    chk("irq_latched", 1'h1, pend);
    chk("irq_masked", 1'h0, serv);
    repeat (4) @(posedge i_clk);
    pulse(MCLR, 1);
    chk("irq_serv", 1'h1, serv);
    chk("irq_bytes", 3'h5, ebytes);
    @(posedge i_clk);
    #1;
    chk("irq_mask_set", 2'h2, {regs.ccr[3], pend});
    jump(TAKEN, 16'hfffc);
    chk("pc_vector", 16'h3ffc, regs.pc);
    pulse(RESTORE, 1);
    chk("ccr_rti", 8'hf5, regs.ccr);
    pulse(MSET, 1);
    chk("ccr_mset", 8'hfd, regs.ccr);
    $display("test interrupt done");
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    i_rstn = 1'b0;
    ce = 1'b1;
    irq = 1'b0;
    use_mem = 1'b0;
    ctl = '0;
    opnd = 8'h00;
    ccr_rst = 8'h15;
    tgt = 16'h0000;
    aop = CRS_OP_NOP;
    req = '{CRS_AM_INH, 8'h00, 8'h00};
    fails = 0;
    compares = 0;
    do_reset();
    t_stack();
    t_alu();
    t_mul();
    t_pc();
    t_ea();
    t_irq();
    final_report();
  end
  // Run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge i_clk);
    fails++;
    final_report();
  end
endmodule
